// >>> hw/dipbe_pkg.sv
// shared constants and types for the dual-input program and block erase sequencer
package dipbe_pkg;
  localparam int CLK_MHZ = 20; // core_clk rate
  // command opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_DPROG = 8'hA2;
  localparam logic [7:0] OP_ERA4K = 8'h20;
  localparam logic [7:0] OP_ERA32K = 8'h52;
  localparam logic [7:0] OP_ERA64K = 8'hD8;
  // self-timed durations in microseconds, plain defaults
  localparam int BYTE_PROG_US = 20;
  localparam int PAGE_PROG_US = 1000;
  localparam int BLOCK_ERASE_US = 4000;
  localparam int BYTE_PROG_CYC = BYTE_PROG_US * CLK_MHZ;
  localparam int PAGE_PROG_CYC = PAGE_PROG_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_US * CLK_MHZ;
  localparam int PAGE_BYTES = 256; // buffer depth, one page
  localparam int TIMER_W = 24;
  localparam int SECTOR_LSB = 16; // 64 Kbyte protection sectors
  // block base masks drop the in-block address bits
  localparam logic [23:0] MASK_4K = 24'hFFF000;
  localparam logic [23:0] MASK_32K = 24'hFF8000;
  localparam logic [23:0] MASK_64K = 24'hFF0000;
  typedef enum logic [1:0] {PH_OPC, PH_ADDR, PH_DATA, PH_IGN} dipbe_phase_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_WRITE, SQ_WAIT} dipbe_seq_t;
  typedef enum logic [1:0] {ER_4K, ER_32K, ER_64K} dipbe_esize_t;
  // command to the flash array
  typedef struct packed {
    logic we;
    logic erase;
    dipbe_esize_t esize;
    logic [23:0] addr;
    logic [7:0] wdata;
  } dipbe_arr_t;
  // status flags seen by a status read
  typedef struct packed {
    logic write_latch_flag;
    logic busy;
    logic prog_erase_error_flag;
  } dipbe_stat_t;
endpackage

// >>> hw/dipbe_seq.sv
// serial command sequencer for dual-input page program and block erase
// Function
// R1 - opcode A2h then three address bytes
// R2 - dual data two bits per clock, msb first
// R3 - program or erase only while latch set
// R4 - data past page end wraps within page
// R5 - keep only the final 256 bytes
// R6 - program buffered bytes, untouched ones stay erased
// R7 - abort program on short address, data or bits
// R8 - protected target: no program, back to idle
// R9 - program abort clears the write latch
// R10 - program self-timed, busy shown meanwhile
// R11 - host should poll busy for throughput
// R12 - latch cleared before cycle completes
// R13 - array failure sets error flag
// R14 - erase opcodes pick 4K, 32K, 64K block
// R15 - erase ignores bytes after the address
// R16 - low address bits ignored inside block
// R17 - erase needs full address and byte boundary
// R18 - protected erase target: nothing erased
// R19 - erase abort clears the write latch
// R20 - erase self-timed, busy shown meanwhile
// R21 - opcode 06h sets latch at deselect
// R22 - count clock edges during each frame
`timescale 1ns/1ns
module dipbe_seq
  import dipbe_pkg::*;
#(
  parameter int BYTE_PROG_CYCLES = BYTE_PROG_CYC,
  parameter int PAGE_PROG_CYCLES = PAGE_PROG_CYC,
  parameter int BLOCK_ERASE_CYCLES = BLOCK_ERASE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  input wire logic upper_data_pin,
  input wire logic [15:0] sector_guard,
  input wire logic arr_fail,
  output dipbe_pkg::dipbe_arr_t arr,
  output dipbe_pkg::dipbe_stat_t stat
);
  import dipbe_pkg::*;

  // program must finish its buffer walk before the timer expires
  if (BYTE_PROG_CYCLES <= PAGE_BYTES || PAGE_PROG_CYCLES <= PAGE_BYTES ||
      BLOCK_ERASE_CYCLES < 1 || BLOCK_ERASE_CYCLES >= (1 << TIMER_W) ||
      PAGE_PROG_CYCLES >= (1 << TIMER_W) || BYTE_PROG_CYCLES >= (1 << TIMER_W)) begin : g_chk
    $error("dipbe_seq: timing parameters out of range");
  end

  // whole module state
  typedef struct packed {
    logic cs_s1, cs_s2, cs_d; // chip select synchroniser and history
    logic sck_s1, sck_s2, sck_d; // serial clock synchroniser and history
    logic si_s1, si_s2;
    logic up_s1, up_s2;
    logic live; // frame accepted while idle
    dipbe_phase_t phase;
    logic [7:0] op;
    logic [7:0] sh; // byte being shifted in
    logic [2:0] bitc; // bits of the current byte
    logic [1:0] bytec; // address bytes received
    logic [23:0] addr;
    logic [7:0] wptr; // next buffer slot, wraps in page
    logic [1:0] nbytes; // data bytes seen, saturates at two
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] valid; // slot holds host data
    dipbe_seq_t seq;
    logic [7:0] rptr;
    logic [TIMER_W-1:0] timer;
    logic fail;
    dipbe_arr_t arr;
    dipbe_stat_t stat;
  } dipbe_state_t;

  dipbe_state_t q, next_q;

  // edges seen on the synchronised pins
  logic sck_rise, cs_fall, cs_rise;
  assign sck_rise = q.sck_s2 & ~q.sck_d;
  assign cs_fall = q.cs_d & ~q.cs_s2;
  assign cs_rise = q.cs_s2 & ~q.cs_d;

  // erase opcode test, shared by decode and checks
  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_ERA4K || op == OP_ERA32K || op == OP_ERA64K;
  endfunction

  // block base mask for an erase opcode
  function automatic logic [23:0] erase_mask(input logic [7:0] op);
    case (op)
      OP_ERA4K: return MASK_4K;
      OP_ERA32K: return MASK_32K;
      default: return MASK_64K;
    endcase
  endfunction

  logic hit; // target sector protected or locked
  assign hit = sector_guard[q.addr[SECTOR_LSB+3:SECTOR_LSB]];

  // next state
  always_comb begin
    logic dual;
    logic [3:0] nbit;
    logic [7:0] sh;
    logic boundary;
    dual = q.phase == PH_DATA;
    nbit = 4'h0;
    sh = 8'h00;
    boundary = q.bitc == 3'h0;
    next_q = q;
    // two flops on every serial pin before use
    next_q.cs_s1 = spi_cs_n;
    next_q.cs_s2 = q.cs_s1;
    next_q.cs_d = q.cs_s2;
    next_q.sck_s1 = spi_sck;
    next_q.sck_s2 = q.sck_s1;
    next_q.sck_d = q.sck_s2;
    next_q.si_s1 = spi_si;
    next_q.si_s2 = q.si_s1;
    next_q.up_s1 = upper_data_pin;
    next_q.up_s2 = q.up_s1;
    next_q.arr.we = 1'b0;
    next_q.arr.erase = 1'b0;
    // frame opens; frames begun while busy are ignored whole
    if (cs_fall) begin
      next_q.live = ~q.stat.busy;
      if (!q.stat.busy) begin
        next_q.phase = PH_OPC;
        next_q.op = 8'h00;
        next_q.bitc = 3'h0;
        next_q.bytec = 2'h0;
        next_q.nbytes = 2'h0;
        next_q.valid = '0;
      end
    end
    // shift on each rising serial clock inside an accepted frame
    if (sck_rise && q.live && !q.cs_s2) begin
      nbit = {1'b0, q.bitc} + (dual ? 4'h2 : 4'h1); // R22
      sh = dual ? {q.sh[5:0], q.up_s2, q.si_s2} : {q.sh[6:0], q.si_s2}; // R2
      next_q.sh = sh;
      next_q.bitc = nbit[2:0];
      if (nbit[3]) begin
        case (q.phase)
          PH_OPC: begin
            next_q.op = sh;
            next_q.phase = (sh == OP_DPROG || is_erase(sh)) ? PH_ADDR : PH_IGN; // R1 R14
          end
          PH_ADDR: begin
            next_q.addr = {q.addr[15:0], sh};
            next_q.bytec = q.bytec + 2'h1;
            if (q.bytec == 2'h2) begin
              // erase drops any later bytes
              next_q.phase = (q.op == OP_DPROG) ? PH_DATA : PH_IGN; // R15
              next_q.wptr = sh;
            end
          end
          PH_DATA: begin
            // overwriting old slots keeps only the last page of data
            next_q.pbuf[q.wptr] = sh; // R5
            next_q.valid[q.wptr] = 1'b1;
            next_q.wptr = q.wptr + 8'h01; // R4
            if (q.nbytes != 2'h2) begin
              next_q.nbytes = q.nbytes + 2'h1;
            end
          end
          default: ;
        endcase
      end
    end
    // frame closes: decide what the command does
    if (cs_rise && q.live) begin
      next_q.live = 1'b0;
      case (q.op)
        OP_WREN: begin
          if (boundary && q.phase != PH_OPC) begin
            next_q.stat.write_latch_flag = 1'b1; // R21
          end
        end
        OP_WRDI: begin
          if (boundary && q.phase != PH_OPC) begin
            next_q.stat.write_latch_flag = 1'b0;
          end
        end
        OP_DPROG: begin
          if (q.stat.write_latch_flag) begin // R3
            if (boundary && q.phase == PH_DATA && q.nbytes != 2'h0 && !hit) begin // R7 R8
              next_q.seq = SQ_WRITE;
              next_q.rptr = 8'h00;
              next_q.timer = (q.nbytes == 2'h1) ? TIMER_W'(BYTE_PROG_CYCLES)
                                                : TIMER_W'(PAGE_PROG_CYCLES); // R10
              next_q.stat.busy = 1'b1;
              next_q.stat.write_latch_flag = 1'b0; // R12
              next_q.stat.prog_erase_error_flag = 1'b0;
              next_q.fail = 1'b0;
            end else begin
              next_q.stat.write_latch_flag = 1'b0; // R9
            end
          end
        end
        OP_ERA4K, OP_ERA32K, OP_ERA64K: begin
          if (q.stat.write_latch_flag) begin // R3
            if (boundary && q.phase == PH_IGN && !hit) begin // R17 R18
              next_q.seq = SQ_WAIT;
              next_q.timer = TIMER_W'(BLOCK_ERASE_CYCLES); // R20
              next_q.arr.erase = 1'b1;
              next_q.arr.addr = q.addr & erase_mask(q.op); // R16
              next_q.arr.esize = (q.op == OP_ERA4K) ? ER_4K :
                                 (q.op == OP_ERA32K) ? ER_32K : ER_64K; // R14
              next_q.stat.busy = 1'b1;
              next_q.stat.write_latch_flag = 1'b0; // R12
              next_q.stat.prog_erase_error_flag = 1'b0;
              next_q.fail = 1'b0;
            end else begin
              next_q.stat.write_latch_flag = 1'b0; // R19
            end
          end
        end
        default: ;
      endcase
    end
    // self-timed cycle; the timer also covers the buffer walk
    if (q.seq != SQ_IDLE) begin
      if (q.timer != '0) begin
        next_q.timer = q.timer - TIMER_W'(1);
      end
      if (arr_fail) begin
        next_q.fail = 1'b1; // R13
      end
    end
    case (q.seq)
      SQ_WRITE: begin
        // slots with no data are skipped, so they stay erased
        if (q.valid[q.rptr]) begin // R6
          next_q.arr.we = 1'b1;
          next_q.arr.addr = {q.addr[23:8], q.rptr}; // R4
          next_q.arr.wdata = q.pbuf[q.rptr];
        end
        next_q.rptr = q.rptr + 8'h01;
        if (q.rptr == 8'hFF) begin
          next_q.seq = SQ_WAIT;
        end
      end
      SQ_WAIT: begin
        if (q.timer == '0) begin
          next_q.seq = SQ_IDLE;
          next_q.stat.busy = 1'b0; // R10 R20
          next_q.stat.prog_erase_error_flag = q.fail | arr_fail; // R13
        end
      end
      default: ;
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign arr = q.arr;
  assign stat = q.stat;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_wren;
    cs_rise && q.live && q.op == OP_WREN && q.bitc == 3'h0 && q.phase != PH_OPC
      |=> stat.write_latch_flag;
  endproperty
  a_wren: assert property (p_wren) else $error("latch not set by 06h"); // R21

  property p_need_latch;
    cs_rise && !stat.write_latch_flag && !stat.busy |=> !stat.busy;
  endproperty
  a_need_latch: assert property (p_need_latch) else $error("ran without latch"); // R3

  property p_prog_abort;
    cs_rise && q.live && q.op == OP_DPROG && stat.write_latch_flag &&
      (q.bitc != 3'h0 || q.nbytes == 2'h0 || q.phase != PH_DATA)
      |=> !stat.busy && !stat.write_latch_flag;
  endproperty
  a_prog_abort: assert property (p_prog_abort) else $error("bad program ran"); // R7 R9

  property p_prog_guard;
    cs_rise && q.live && q.op == OP_DPROG && hit |=> !stat.busy && !stat.write_latch_flag;
  endproperty
  a_prog_guard: assert property (p_prog_guard) else $error("protected program ran"); // R8

  property p_erase_abort;
    cs_rise && q.live && is_erase(q.op) && stat.write_latch_flag &&
      (q.bitc != 3'h0 || q.phase != PH_IGN || hit)
      |=> !stat.busy && !stat.write_latch_flag;
  endproperty
  a_erase_abort: assert property (p_erase_abort) else $error("bad erase ran"); // R17 R18 R19

  property p_busy_latch;
    stat.busy |-> !stat.write_latch_flag;
  endproperty
  a_busy_latch: assert property (p_busy_latch) else $error("latch set while busy"); // R12

  property p_wrap;
    arr.we |-> arr.addr[23:8] == q.addr[23:8] && q.valid[arr.addr[7:0]];
  endproperty
  a_wrap: assert property (p_wrap) else $error("write outside page"); // R4 R6

  property p_erase_base;
    arr.erase |-> (arr.addr & ~erase_mask(q.op)) == 24'h000000 && stat.busy;
  endproperty
  a_erase_base: assert property (p_erase_base) else $error("erase base not aligned"); // R16

  property p_erase_busy;
    $rose(stat.busy) && arr.erase |-> stat.busy [*8];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase busy too short"); // R20

  property p_done;
    q.seq == SQ_WAIT && q.timer == '0 |=> !stat.busy &&
      stat.prog_erase_error_flag == $past(q.fail | arr_fail);
  endproperty
  a_done: assert property (p_done) else $error("cycle end wrong"); // R10 R13

  property p_ignore;
    sck_rise && q.phase == PH_IGN && is_erase(q.op) |=> $stable(q.addr) && !arr.we;
  endproperty
  a_ignore: assert property (p_ignore) else $error("erase took extra bytes"); // R15

  property p_dual;
    sck_rise && q.live && !q.cs_s2 && q.phase == PH_DATA && q.bitc == 3'h6
      |=> q.bitc == 3'h0 && q.wptr == $past(q.wptr) + 8'h01;
  endproperty
  a_dual: assert property (p_dual) else $error("dual byte not every four clocks"); // R2 R22
endmodule

// >>> dv/dipbe_host.sv
// host controller model that drives the serial frame pins
`timescale 1ns/1ns
module dipbe_host (
  input wire logic core_clk,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_si,
  output logic upper_data_pin
);
  // idle: deselected, clock parked low
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
    upper_data_pin = 1'b1;
  end
  // select, then give the sync flops time to see the fall
  task automatic open();
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // one serial clock of 8 core cycles, data set while clock is low
  task automatic tick(input logic hi, input logic lo);
    upper_data_pin <= hi;
    spi_si <= lo;
    repeat (4) @(posedge core_clk);
    spi_sck <= 1'b1;
    repeat (4) @(posedge core_clk);
    spi_sck <= 1'b0;
  endtask
  // single-bit byte, msb first; the unused upper pin toggles
  task automatic single(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick(~upper_data_pin, b[i]);
  endtask
  // dual byte: high bit of each pair on the upper pin
  task automatic dual(input logic [7:0] b);
    for (int i = 3; i >= 0; i--) tick(b[2*i+1], b[2*i]);
  endtask
  // deselect; released data lines must not keep their last value
  task automatic close();
    repeat (4) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    spi_si <= ~spi_si;
    upper_data_pin <= ~upper_data_pin;
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the program and erase sequencer
`timescale 1ns/1ns
module testbench;
  import dipbe_pkg::*;
  localparam int BP = 300; // short timings keep the run brief
  localparam int PP = 400;
  localparam int BE = 50;
  logic core_clk, rst_n, arr_fail;
  logic spi_cs_n, spi_sck, spi_si, upper_data_pin;
  logic [15:0] sector_guard;
  dipbe_arr_t arr;
  dipbe_stat_t stat;
  logic [33:0] exp_q[$]; // expected array commands, oldest first
  logic [7:0] dat[258];
  logic [31:0] seed;
  int n_errors, compares;
  // abort table: opcode, address bytes, data bytes, stray clocks, guarded
  logic [7:0] ab_op[7] = '{OP_DPROG, OP_DPROG, OP_DPROG, OP_DPROG, OP_ERA4K, OP_ERA32K, OP_ERA64K};
  int ab_na[7] = '{3, 2, 3, 3, 2, 3, 3};
  int ab_nd[7] = '{1, 0, 0, 1, 0, 0, 1};
  int ab_ex[7] = '{1, 0, 0, 0, 0, 1, 0};
  logic ab_gd[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] er_op[3] = '{OP_ERA4K, OP_ERA32K, OP_ERA64K};
  logic [23:0] er_mk[3] = '{MASK_4K, MASK_32K, MASK_64K};
  dipbe_esize_t er_sz[3] = '{ER_4K, ER_32K, ER_64K};

  dipbe_seq #(.BYTE_PROG_CYCLES(BP), .PAGE_PROG_CYCLES(PP), .BLOCK_ERASE_CYCLES(BE)) dipbe_seq_i (
    .core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_si(spi_si), .upper_data_pin(upper_data_pin), .sector_guard(sector_guard),
    .arr_fail(arr_fail), .arr(arr), .stat(stat));
  dipbe_host dipbe_host_i (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_si(spi_si), .upper_data_pin(upper_data_pin));

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // xorshift source for data and addresses
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // compares an array command or any wide value
  task automatic chk_arr(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compares the status flags
  task automatic chk_stat(input logic [2:0] exp);
    chk_arr({31'h0, stat}, {31'h0, exp});
  endtask
  // note one byte write
  task automatic pw(input logic [23:0] a, input logic [7:0] d);
    exp_q.push_back({2'b10, a, d});
  endtask
  // one whole frame; trailing bytes are dual only for program
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na, nd, ex);
    dipbe_host_i.open();
    dipbe_host_i.single(op);
    for (int i = 2; i > 2 - na; i--) dipbe_host_i.single(a[8*i+:8]);
    for (int i = 0; i < nd; i++) begin
      if (op == OP_DPROG) dipbe_host_i.dual(dat[i]);
      else dipbe_host_i.single(dat[i]);
    end
    repeat (ex) dipbe_host_i.tick(1'b0, 1'b1);
    dipbe_host_i.close();
  endtask
  // let the deselect decision land
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask
  // write enable; only the latch is looked at, the error flag may linger
  task automatic wren();
    cmd(OP_WREN, 24'h000000, 0, 0, 0);
    settle();
    chk_arr({33'h0, stat.write_latch_flag}, 34'h1);
  endtask
  // poll busy, check its length and that all notes were used
  task automatic wait_idle(input int lo);
    int n;
    n = 0;
    while (stat.busy !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk_arr(34'(n >= lo && n <= lo + 10), 34'h1);
    chk_arr(34'(exp_q.size()), 34'h0);
    repeat (4) @(negedge core_clk);
  endtask
  // every array pulse must match the oldest note; surplus pulses fail
  always @(negedge core_clk) begin
    if (rst_n === 1'b1 && (arr.we === 1'b1 || arr.erase === 1'b1)) begin
      if (exp_q.size() == 0) chk_arr({arr.we, arr.erase, arr.addr, arr.wdata}, '1);
      else chk_arr({arr.we, arr.erase, arr.addr,
        arr.erase ? {6'h00, arr.esize} : arr.wdata}, exp_q.pop_front());
    end
  end
  // verdict and end of run
  task automatic end_sim();
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog, well beyond the expected run length
  initial begin
    #3000000;
    n_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    logic [23:0] a;
    seed = 32'h0000002F;
    rst_n = 1'b0;
    arr_fail = 1'b0;
    sector_guard = 16'h8000; // top sector guarded
    for (int i = 0; i < 258; i++) dat[i] = 8'(xs());
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    chk_stat(3'b000);
    cmd(OP_DPROG, 24'h010000, 3, 1, 0);
    settle();
    chk_stat(3'b000);
    // three bytes from the last two slots wrap to slot zero
    wren();
    a = 24'(xs());
    a[19] = 1'b0;
    a[7:0] = 8'hFE;
    pw({a[23:8], 8'h00}, dat[2]);
    pw({a[23:8], 8'hFE}, dat[0]);
    pw({a[23:8], 8'hFF}, dat[1]);
    cmd(OP_DPROG, a, 3, 3, 0);
    settle();
    chk_stat(3'b010);
    wait_idle(PP - 6);
    // 258 bytes: the first two are overwritten
    wren();
    a = 24'(xs());
    a[19] = 1'b0;
    a[7:0] = 8'h00;
    for (int k = 0; k < 256; k++) pw({a[23:8], 8'(k)}, dat[k < 2 ? k + 256 : k]);
    cmd(OP_DPROG, a, 3, 258, 0);
    settle();
    wait_idle(PP - 6);
    // aborted and refused frames leave nothing behind
    for (int k = 0; k < 7; k++) begin
      wren();
      a = 24'(xs());
      a[19:16] = ab_gd[k] ? 4'hF : 4'h1;
      cmd(ab_op[k], a, ab_na[k], ab_nd[k], ab_ex[k]);
      settle();
      chk_stat(3'b000);
    end
    // single byte with a failing array
    wren();
    a = 24'(xs());
    a[19] = 1'b0;
    pw(a, dat[0]);
    cmd(OP_DPROG, a, 3, 1, 0);
    settle();
    @(posedge core_clk);
    arr_fail <= 1'b1;
    wait_idle(BP - 7);
    chk_stat(3'b001);
    @(posedge core_clk);
    arr_fail <= 1'b0;
    // every erase size, with a stray byte after the address
    for (int k = 0; k < 3; k++) begin
      wren();
      a = 24'(xs());
      a[19] = 1'b0;
      exp_q.push_back({2'b01, a & er_mk[k], 6'h00, er_sz[k]});
      cmd(er_op[k], a, 3, 1, 0);
      settle();
      chk_stat(3'b010);
      wait_idle(BE - 6);
    end
    wren();
    cmd(OP_WRDI, 24'h000000, 0, 0, 0);
    settle();
    chk_stat(3'b000);
    end_sim();
  end
endmodule
